// ===== rtl/tmg_defs.vh
// Constants for the timing and management payload generator.
//
// Behaviour
// (RULE_01) Payload opens with a 16-bit byte count of the bytes that follow; the code counts every byte, including the two count bytes.
// (RULE_02) Major protocol version field is four bits, always zero.
// (RULE_03) Minor protocol version field is four bits, always zero.
// (RULE_04) Preamble repetition count is four bits, legal values 1,3,5,7,9.
// (RULE_05) Receiver votes preamble copies but takes signal flag from last copy.
// (RULE_06) Timing repetition count is four bits, legal values 1,3,5,7,9.
// (RULE_07) Receiver votes timing copies but takes wake bits from last copy.
// (RULE_08) Transmitter uses bootstrap major field as sequence root.
// (RULE_09) Transmitter uses bootstrap minor field as noise sequence seed.
// (RULE_10) Emission count is entries minus one; entry zero is next bootstrap.
// (RULE_11) Emission times strictly increase through the list.
// (RULE_12) Two wake bits carried for the next emitted frame's bootstrap.
// (RULE_13) Transmitter count is entries minus one, one to sixty-four.
// (RULE_14) Group number 0..127 rises by one per packet and wraps.
// (RULE_15) Override code 000 is normal, 111 forces fresh configuration.
// (RULE_16) Station entry: offset, level, filter index, 29 reserved ones.
// (RULE_17) Structure ends with carrier offset then six reserved ones.
// (RULE_18) Each timing entry is 32-bit seconds then 32-bit nanoseconds.
// (RULE_19) Closing check covers every bit from byte count up to it.
// (RULE_20) Station entry starts with a 13-bit station address.
// (RULE_21) First segment marker is one, later segment markers zero.
// (RULE_22) Every segment uses payload type 76.
// (RULE_23) Receiver drops payloads with a bad check and keeps old settings.
`ifndef TMG_DEFS_VH
`define TMG_DEFS_VH
`define TMG_VER_MAJOR 4'h0
`define TMG_VER_MINOR 4'h0
`define TMG_PAYLOAD_TYPE 7'h4C
`define TMG_GROUP_MAX 7'h7F
`define TMG_CRC_POLY 16'h1021
`define TMG_CRC_INIT 16'hFFFF
`define TMG_RSV_STRUCT 6'h3F
`define TMG_RSV_ENTRY 29'h1FFFFFFF
`define TMG_RSV_RLS 2'h3
`define TMG_OVR_NORMAL 3'h0
`define TMG_OVR_FORCE 3'h7
`define TMG_HDR_BITS 96
`define TMG_ENTRY_BITS 64
`define TMG_STN_BITS 64
`define TMG_RLS_BITS 16
`define TMG_TAIL_BITS 16
`define TMG_ENTRIES 64
// Register map, word addresses on the plain port.
`define TMG_A_CTRL 8'h00
`define TMG_A_STRUCT0 8'h01
`define TMG_A_STRUCT1 8'h02
`define TMG_A_STRUCT2 8'h03
`define TMG_A_RLS 8'h04
`define TMG_A_STATUS 8'h05
`define TMG_A_GROUP 8'h06
`define TMG_A_SEG 8'h07
`define TMG_A_STN_HI 8'h08
`define TMG_A_TIME_S 8'h40
`define TMG_A_TIME_N 8'h80
`define TMG_A_STN 8'hC0
`define TMG_ERR_REP 0
`define TMG_ERR_ORDER 1
`define TMG_ERR_BUSY 2
`endif

// ===== rtl/tmg_framer.v
// Timing and management payload generator with a plain register port.
`timescale 1ns/1ps
module tmg_framer (
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata_ff,
  input wire out_ready,
  output reg [7:0] out_byte_ff,
  output reg out_valid_ff,
  output reg out_first_ff,
  output reg out_last_ff,
  output reg seg_start_ff,
  output reg seg_marker_ff,
  output reg [6:0] seg_ptype_ff,
  output reg busy_ff
);
`include "tmg_defs.vh"

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function rep_ok;
    input [3:0] v;
    begin
      rep_ok = (v == 4'h1) || (v == 4'h3) || (v == 4'h5) || (v == 4'h7) || (v == 4'h9);
    end
  endfunction

  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] d;
    integer k;
    reg [15:0] t;
    begin
      t = c;
      for (k = 7; k >= 0; k = k - 1) begin
        if (t[15] ^ d[k]) begin
          t = {t[14:0], 1'b0} ^ `TMG_CRC_POLY;
        end else begin
          t = {t[14:0], 1'b0};
        end
      end
      crc_byte = t;
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam S_IDLE = 5'h01;
  localparam S_HDR = 5'h02;
  localparam S_TIME = 5'h04;
  localparam S_STN = 5'h08;
  localparam S_TAIL = 5'h10;

  reg [4:0] state_ff;
  reg [31:0] s0_ff;
  reg [31:0] s1_ff;
  reg [31:0] s2_ff;
  reg [13:0] rls_ff;
  reg [5:0] seg_len_ff;
  reg [6:0] group_ff;
  reg [6:0] group_top_ff;
  reg [2:0] err_ff;
  reg [31:0] sec_mem [0:`TMG_ENTRIES-1];
  reg [31:0] ns_mem [0:`TMG_ENTRIES-1];
  reg [34:0] stn_mem [0:`TMG_ENTRIES-1];
  reg [5:0] idx_ff;
  reg [2:0] bidx_ff;
  reg [15:0] crc_ff;
  reg [15:0] len_ff;
  reg [10:0] seg_cnt_ff;
  reg [2:0] stn_hi_ff;

  // Structure fields: s0 = rep_pre, rep_tim, bs_major, bs_minor, min_time, bw, bsr,
  // s1 = preamble_structure, wake bits, emission count, station count, override,
  // s2 = filter count, carrier offset.
  wire [3:0] rep_pre = s0_ff[31:28];
  wire [3:0] rep_tim = s0_ff[27:24];
  wire [5:0] n_emis = s1_ff[21:16];
  wire [5:0] n_stn = s1_ff[13:8];
  wire [2:0] ovr = s1_ff[2:0];
  wire is_wr_data = wr && (addr[7:6] != 2'h0);

  // Emission times must strictly increase across the used entries.
  wire [63:0] ordered;
  genvar g;
  generate
    for (g = 0; g < `TMG_ENTRIES; g = g + 1) begin : g_ord
      if (g == 0) begin : g_first
        assign ordered[g] = 1'b1;
      end else begin : g_rest
        // (RULE_11) strict increase check
        assign ordered[g] = (g > n_emis) ||
          ({sec_mem[g], ns_mem[g]} > {sec_mem[g-1], ns_mem[g-1]});
      end
    end
  endgenerate

  // (RULE_01) byte count
  wire [15:0] calc_len = 16'd12 + {7'h0, n_emis, 3'h0} + 16'd8 +
    {7'h0, n_stn, 3'h0} + 16'd8 + 16'd2 + 16'd2;

  wire start_ok = rep_ok(rep_pre) && rep_ok(rep_tim) && (&ordered);

  // ----------------------------------------------------------------
  // Byte selection
  // ----------------------------------------------------------------
  reg [95:0] hdr;
  reg [63:0] ent;
  reg [63:0] stn;
  reg [7:0] cur;
  always @* begin
    // (RULE_02) (RULE_03) version zero
    // (RULE_17) carrier offset then reserved ones
    // Exactly 96 bits; s0 bits 1:0 are unused so the header never spills a byte.
    hdr = {
      len_ff,
      `TMG_VER_MAJOR,
      `TMG_VER_MINOR,
      s0_ff[31:2],
      s1_ff[31:24],
      s1_ff[23:22],
      n_emis,
      n_stn,
      group_ff,
      ovr,
      s2_ff[3:2],
      s2_ff[1:0],
      `TMG_RSV_STRUCT
    };
    // (RULE_18) seconds then nanoseconds
    ent = {sec_mem[idx_ff], ns_mem[idx_ff]};
    // (RULE_16) (RULE_20) station entry with reserved tail
    stn = {stn_mem[idx_ff], `TMG_RSV_ENTRY};
    cur = 8'h00;
    case (state_ff)
      S_HDR: begin
        cur = hdr[8'd95 - {idx_ff[3:0], 3'h0} -: 8];
      end
      S_TIME: begin
        cur = ent[6'd63 - {bidx_ff, 3'h0} -: 8];
      end
      S_STN: begin
        cur = stn[6'd63 - {bidx_ff, 3'h0} -: 8];
      end
      S_TAIL: begin
        case (bidx_ff)
          3'h0: cur = {rls_ff[13:10], rls_ff[9:6]};
          3'h1: cur = {rls_ff[5:0], `TMG_RSV_RLS};
          3'h2: cur = crc_ff[15:8];
          default: cur = crc_ff[7:0];
        endcase
      end
      default: cur = 8'h00;
    endcase
  end

  wire step = (state_ff != S_IDLE) && (!out_valid_ff || out_ready);
  wire last_byte = (state_ff == S_TAIL) && (bidx_ff == 3'h3);
  wire seg_wrap = (seg_cnt_ff == {seg_len_ff, 5'h1F});

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= S_IDLE;
      idx_ff <= 6'h00;
      bidx_ff <= 3'h0;
      crc_ff <= `TMG_CRC_INIT;
      len_ff <= 16'h0000;
      out_byte_ff <= 8'h00;
      out_valid_ff <= 1'b0;
      out_first_ff <= 1'b0;
      out_last_ff <= 1'b0;
      seg_start_ff <= 1'b0;
      seg_marker_ff <= 1'b0;
      seg_ptype_ff <= 7'h00;
      seg_cnt_ff <= 11'h000;
      group_ff <= 7'h00;
      busy_ff <= 1'b0;
      err_ff <= 3'h0;
    end else begin
      // Segment flags stand with their byte until the sink takes it.
      if (out_valid_ff && out_ready) begin
        out_valid_ff <= 1'b0;
        seg_start_ff <= 1'b0;
      end
      if (wr && (addr == `TMG_A_STATUS)) begin
        err_ff <= err_ff & ~wdata[2:0];
      end
      if (wr && (addr == `TMG_A_CTRL) && wdata[0]) begin
        if (state_ff != S_IDLE) begin
          err_ff[`TMG_ERR_BUSY] <= 1'b1;
        end else if (!start_ok) begin
          // (RULE_04) (RULE_06) refuse illegal repetition counts
          // Flags are sticky so a later refusal never hides an earlier one.
          if (!(rep_ok(rep_pre) && rep_ok(rep_tim))) begin
            err_ff[`TMG_ERR_REP] <= 1'b1;
          end
          if (!(&ordered)) begin
            err_ff[`TMG_ERR_ORDER] <= 1'b1;
          end
        end else begin
          state_ff <= S_HDR;
          idx_ff <= 6'h00;
          bidx_ff <= 3'h0;
          len_ff <= calc_len;
          crc_ff <= `TMG_CRC_INIT;
          busy_ff <= 1'b1;
          seg_cnt_ff <= 11'h000;
        end
      end
      if (step) begin
        out_byte_ff <= cur;
        out_valid_ff <= 1'b1;
        out_first_ff <= (state_ff == S_HDR) && (idx_ff == 6'h00);
        out_last_ff <= last_byte;
        // A segment opens at count zero; seg_wrap marks the close of the one before.
        // (RULE_21) marker on first segment only
        seg_start_ff <= (seg_cnt_ff == 11'h000);
        if (seg_cnt_ff == 11'h000) begin
          seg_marker_ff <= (state_ff == S_HDR) && (idx_ff == 6'h00);
          // (RULE_22) payload type
          seg_ptype_ff <= `TMG_PAYLOAD_TYPE;
        end
        seg_cnt_ff <= seg_wrap ? 11'h000 : seg_cnt_ff + 11'h001;
        // (RULE_19) check spans all bytes before it
        if (!(state_ff == S_TAIL && bidx_ff[1])) begin
          crc_ff <= crc_byte(crc_ff, cur);
        end
        case (state_ff)
          S_HDR: begin
            if (idx_ff == 6'd11) begin
              idx_ff <= 6'h00;
              bidx_ff <= 3'h0;
              state_ff <= S_TIME;
            end else begin
              idx_ff <= idx_ff + 6'h01;
            end
          end
          S_TIME: begin
            bidx_ff <= bidx_ff + 3'h1;
            // (RULE_10) count plus one entries
            if (bidx_ff == 3'h7) begin
              if (idx_ff == n_emis) begin
                idx_ff <= 6'h00;
                state_ff <= S_STN;
              end else begin
                idx_ff <= idx_ff + 6'h01;
              end
            end
          end
          S_STN: begin
            bidx_ff <= bidx_ff + 3'h1;
            // (RULE_13) count plus one stations
            if (bidx_ff == 3'h7) begin
              if (idx_ff == n_stn) begin
                idx_ff <= 6'h00;
                state_ff <= S_TAIL;
              end else begin
                idx_ff <= idx_ff + 6'h01;
              end
            end
          end
          S_TAIL: begin
            bidx_ff <= bidx_ff + 3'h1;
            if (last_byte) begin
              state_ff <= S_IDLE;
              busy_ff <= 1'b0;
              // (RULE_14) group rises and wraps
              group_ff <= (group_ff >= group_top_ff) ? 7'h00 : group_ff + 7'h01;
            end
          end
          default: state_ff <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Table contents may change while a payload is being sent; software should wait for idle.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s0_ff <= 32'h11000000;
      s1_ff <= 32'h00000000;
      s2_ff <= 32'h00000000;
      rls_ff <= 14'h0000;
      seg_len_ff <= 6'h2E;
      group_top_ff <= `TMG_GROUP_MAX;
      stn_hi_ff <= 3'h0;
    end else if (wr) begin
      case (addr)
        `TMG_A_STRUCT0: s0_ff <= wdata;
        // (RULE_12) (RULE_15) wake bits and override code
        `TMG_A_STRUCT1: s1_ff <= wdata;
        `TMG_A_STRUCT2: s2_ff <= wdata;
        `TMG_A_RLS: rls_ff <= wdata[13:0];
        `TMG_A_GROUP: group_top_ff <= wdata[6:0];
        `TMG_A_SEG: seg_len_ff <= wdata[5:0];
        // A station entry is wider than one word; its top bits wait here.
        `TMG_A_STN_HI: stn_hi_ff <= wdata[2:0];
        default: seg_len_ff <= seg_len_ff;
      endcase
    end
  end

  always @(posedge clk) begin
    if (is_wr_data) begin
      case (addr[7:6])
        2'h1: sec_mem[addr[5:0]] <= wdata;
        2'h2: ns_mem[addr[5:0]] <= wdata;
        default: stn_mem[addr[5:0]] <= {stn_hi_ff, wdata};
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        `TMG_A_STRUCT0: rdata_ff <= s0_ff;
        `TMG_A_STRUCT1: rdata_ff <= s1_ff;
        `TMG_A_STRUCT2: rdata_ff <= s2_ff;
        `TMG_A_RLS: rdata_ff <= {18'h0, rls_ff};
        `TMG_A_STATUS: rdata_ff <= {9'h000, group_ff, 5'h00, err_ff, 7'h00, busy_ff};
        `TMG_A_GROUP: rdata_ff <= {25'h0, group_top_ff};
        `TMG_A_SEG: rdata_ff <= {26'h0, seg_len_ff};
        default: rdata_ff <= 32'h00000000;
      endcase
    end
  end

endmodule // tmg_framer

// ===== testbench/tmg_framer_properties.sv
// Stream-side assertions for the timing payload generator.
`timescale 1ns/1ps
module tmg_framer_properties (
  input wire clk,
  input wire rst,
  input wire out_ready,
  input wire [7:0] out_byte_ff,
  input wire out_valid_ff,
  input wire out_first_ff,
  input wire out_last_ff,
  input wire seg_start_ff,
  input wire seg_marker_ff,
  input wire [6:0] seg_ptype_ff,
  input wire busy_ff
);
  reg [15:0] idx_ff;
  wire acc = out_valid_ff && out_ready;
  wire at2 = out_valid_ff && idx_ff == 16'h0002;
  // Byte index within the payload, so header fields can be located.
  always @(posedge clk or posedge rst) begin
    if (rst) idx_ff <= 16'h0000;
    else if (acc) idx_ff <= out_last_ff ? 16'h0000 : idx_ff + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  seg_type_a:
    assert property (seg_start_ff |-> seg_ptype_ff == 7'h4C) else $error("bad segment type");
  first_marker_a:
    assert property (out_valid_ff && out_first_ff |-> seg_start_ff && seg_marker_ff)
      else $error("first segment unmarked");
  later_marker_a:
    assert property (seg_start_ff && !out_first_ff |-> !seg_marker_ff)
      else $error("later segment marked");
  byte_hold_a:
    assert property (out_valid_ff && !out_ready |=> out_valid_ff && $stable(out_byte_ff))
      else $error("byte not held");
  version_zero_a:
    assert property (at2 |-> out_byte_ff == 8'h00) else $error("version not zero");
  rep_legal_a:
    assert property (out_valid_ff && idx_ff == 16'h0003 |->
      out_byte_ff[7:4] inside {4'h1, 4'h3, 4'h5, 4'h7, 4'h9} &&
      out_byte_ff[3:0] inside {4'h1, 4'h3, 4'h5, 4'h7, 4'h9}) else $error("bad repeat count");
  override_code_a:
    assert property (out_valid_ff && idx_ff == 16'h000A |-> out_byte_ff[4:2] inside {3'h0, 3'h7})
      else $error("bad override code");
  struct_rsv_a:
    assert property (out_valid_ff && idx_ff == 16'h000B |-> out_byte_ff[5:0] == 6'h3F)
      else $error("reserved bits not set");
  busy_end_a:
    assert property (acc && out_last_ff |-> ##[1:2] !busy_ff) else $error("busy stuck");
  cover property (seg_start_ff && !out_first_ff);
  cover property (out_valid_ff && !out_ready);
  cover property (acc && out_last_ff);
endmodule // tmg_framer_properties
bind tmg_framer tmg_framer_properties u_props (.clk(clk), .rst(rst), .out_ready(out_ready),
  .out_byte_ff(out_byte_ff), .out_valid_ff(out_valid_ff), .out_first_ff(out_first_ff),
  .out_last_ff(out_last_ff), .seg_start_ff(seg_start_ff), .seg_marker_ff(seg_marker_ff),
  .seg_ptype_ff(seg_ptype_ff), .busy_ff(busy_ff));

// ===== testbench/tmg_sink.sv
// Transmitter-side byte sink with optional random back-pressure.
`timescale 1ns/1ps
module tmg_sink (
  input wire clk,
  input wire stall_en,
  input wire [7:0] out_byte_ff,
  input wire out_valid_ff,
  input wire out_last_ff,
  output reg out_ready
);
  reg [7:0] rx_q[$];
  reg [15:0] crc_q = 16'hFFFF;
  reg [15:0] nb;
  reg [7:0] boot_q = 8'h00;
  reg [7:0] rep_q = 8'h00;
  reg [1:0] wake_q = 2'h0;
  integer n_good = 0;
  function [15:0] crc_step(input [15:0] c, input [7:0] d);
    integer b;
    begin
      crc_step = c;
      for (b = 7; b >= 0; b = b - 1)
        crc_step = {crc_step[14:0], 1'b0} ^ ((crc_step[15] ^ d[b]) ? 16'h1021 : 16'h0000);
    end
  endfunction
  initial out_ready = 1'b0;
  always @(posedge clk) begin
    if (out_valid_ff && out_ready) begin
      rx_q.push_back(out_byte_ff);
      nb = crc_step(crc_q, out_byte_ff);
      crc_q <= out_last_ff ? 16'hFFFF : nb;
      if (out_last_ff && nb == 16'h0000) begin
        n_good <= n_good + 1;
        boot_q <= rx_q[4];
        rep_q <= rx_q[3];
        wake_q <= rx_q[7][1:0];
      end
    end
    out_ready <= stall_en ? ($urandom_range(1, 0) != 0) : 1'b1;
  end
endmodule // tmg_sink

// ===== testbench/tmg_framer_tb_top.sv
// Self-checking bench for the timing payload generator.
`timescale 1ns/1ps
module tmg_framer_tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h00000000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg stall_en = 1'b0;
  wire [31:0] rdata_ff;
  wire [7:0] out_byte_ff;
  wire [6:0] seg_ptype_ff;
  wire out_ready, out_valid_ff, out_first_ff, out_last_ff, seg_start_ff, seg_marker_ff, busy_ff;
  integer fails = 0;
  integer n_tests = 0;
  integer grp = 0;
  integer k;
  reg [31:0] rv;
  reg [63:0] tq[0:63];
  reg [34:0] sq[0:63];
  integer npk = 0;
  always #2.5 clk = ~clk;
  tmg_framer u_tmg_framer (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_ff(rdata_ff), .out_ready(out_ready), .out_byte_ff(out_byte_ff),
    .out_valid_ff(out_valid_ff), .out_first_ff(out_first_ff), .out_last_ff(out_last_ff),
    .seg_start_ff(seg_start_ff), .seg_marker_ff(seg_marker_ff), .seg_ptype_ff(seg_ptype_ff),
    .busy_ff(busy_ff));
  tmg_sink u_tmg_sink (.clk(clk), .stall_en(stall_en), .out_byte_ff(out_byte_ff),
    .out_valid_ff(out_valid_ff), .out_last_ff(out_last_ff), .out_ready(out_ready));
  task test_done;
    begin
      if (fails == 0 && n_tests > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  task chk(input [95:0] seen, input [95:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Read data stands from the cycle after the strobe until the next read.
  task rd_stat(input [31:0] exp);
    begin
      addr <= 8'h05;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata_ff, exp | (grp << 16));
      @(posedge clk);
    end
  endtask
  // Groups wrap after the maximum of one that the bench programs.
  task wait_idle;
    begin
      for (k = 0; k < 20000 && (busy_ff !== 1'b0 || out_valid_ff !== 1'b0); k = k + 1)
        @(posedge clk);
      if (k == 20000) fails = fails + 1;
      @(posedge clk);
      grp = (grp == 1) ? 0 : grp + 1;
    end
  endtask
  function [15:0] crc8(input [15:0] c, input [7:0] d);
    integer b;
    begin
      crc8 = c;
      for (b = 7; b >= 0; b = b - 1)
        crc8 = {crc8[14:0], 1'b0} ^ ((crc8[15] ^ d[b]) ? 16'h1021 : 16'h0000);
    end
  endfunction
  task run_pkt(input integer ne, input integer nx, input [7:0] rep, input [2:0] ovr, input st);
    reg [79:0] s;
    reg [95:0] h;
    reg [63:0] t;
    reg [15:0] c;
    reg [6:0] gq;
    integer i, j, b, tot;
    begin
      stall_en <= st;
      s = {8'h00, rep, $urandom(), ne[5:0], nx[5:0], 7'h00, ovr, 4'h4, 6'h3F};
      wr_reg(8'h01, {s[71:64], s[63:42], 2'h0});
      wr_reg(8'h02, {s[41:32], s[31:26], 2'h0, s[25:20], 5'h00, s[12:10]});
      wr_reg(8'h03, {28'h0000000, s[9:6]});
      for (i = 0; i <= ne; i = i + 1) begin
        tq[i] = {32'd100 + i * 3, $urandom_range(999999999, 0)};
        wr_reg(8'h40 + i, tq[i][63:32]);
        wr_reg(8'h80 + i, tq[i][31:0]);
      end
      for (i = 0; i <= nx; i = i + 1) begin
        rv = $urandom();
        sq[i] = {rv[2:0], $urandom()};
        wr_reg(8'h08, {29'h0, sq[i][34:32]});
        wr_reg(8'hC0 + i, sq[i][31:0]);
      end
      rv = $urandom();
      wr_reg(8'h04, rv);
      wr_reg(8'h00, 32'h1);
      gq = grp[6:0];
      wait_idle;
      npk = npk + 1;
      tot = 12 + 8 * (ne + 1) + 8 * (nx + 1) + 4;
      chk(u_tmg_sink.rx_q.size(), tot);
      for (i = 0; i < 12; i = i + 1) h = {h[87:0], u_tmg_sink.rx_q[i]};
      chk(h, {tot[15:0], s[79:20], gq, s[12:0]});
      for (i = 0; i <= ne; i = i + 1) begin
        for (j = 0; j < 8; j = j + 1) t = {t[55:0], u_tmg_sink.rx_q[12 + 8 * i + j]};
        chk(t, tq[i]);
      end
      for (i = 0; i <= nx; i = i + 1) begin
        b = 12 + 8 * (ne + 1) + 8 * i;
        for (j = 0; j < 8; j = j + 1) t = {t[55:0], u_tmg_sink.rx_q[b + j]};
        chk(t, {sq[i], 29'h1FFFFFFF});
      end
      c = 16'hFFFF;
      for (i = 0; i < tot - 2; i = i + 1) c = crc8(c, u_tmg_sink.rx_q[i]);
      chk({u_tmg_sink.rx_q[tot - 2], u_tmg_sink.rx_q[tot - 1]}, c);
      chk({u_tmg_sink.rx_q[tot - 4], u_tmg_sink.rx_q[tot - 3]}, {rv[13:0], 2'h3});
      chk(u_tmg_sink.n_good, npk);
      chk(u_tmg_sink.boot_q, s[63:56]);
      chk(u_tmg_sink.rep_q, rep);
      chk(u_tmg_sink.wake_q, s[33:32]);
      u_tmg_sink.rx_q.delete();
      rd_stat(32'h0);
    end
  endtask
  initial begin
    #400000;
    fails = fails + 1;
    test_done;
  end
  initial begin
    rv = $urandom(23195);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_stat(32'h0);
    wr_reg(8'h06, 32'h1);
    wr_reg(8'h07, 32'h0);
    run_pkt(0, 0, 8'h11, 3'h0, 1'b0);
    run_pkt(3, 1, 8'h35, 3'h7, 1'b1);
    run_pkt(63, 63, 8'h97, 3'h0, 1'b1);
    wr_reg(8'h01, 32'h21000000);
    wr_reg(8'h00, 32'h1);
    rd_stat(32'h100);
    wr_reg(8'h05, 32'h7);
    wr_reg(8'h01, 32'h11000000);
    wr_reg(8'h02, 32'h00010000);
    for (k = 0; k < 4; k = k + 1) wr_reg(k[1] ? 8'h80 + k[0] : 8'h40 + k[0], k[1] ? 0 : 5);
    wr_reg(8'h00, 32'h1);
    rd_stat(32'h200);
    wr_reg(8'h05, 32'h7);
    wr_reg(8'h41, 32'h6);
    wr_reg(8'h00, 32'h1);
    wr_reg(8'h00, 32'h1);
    wait_idle;
    u_tmg_sink.rx_q.delete();
    rd_stat(32'h400);
    wr_reg(8'h05, 32'h7);
    rd_stat(32'h0);
    test_done;
  end
endmodule // tmg_framer_tb_top
